// >>> src/fir_id_readout.sv
// Identification and parameter read logic behind the serial flash pins
`timescale 1ns/100ps
`default_nettype none
module fir_id_readout
  import fir_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5e, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h12, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40, // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h13, // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // Device mode from the rest of the chip
  input wire logic qpi_mode,
  input wire logic power_down,
  // Parameter area lookup
  output logic [7:0] sfdp_addr,
  input wire logic [7:0] sfdp_data
);
  fir_state_type r;
  fir_state_type next_r;
  logic rise;
  logic fall;
  logic [5:0] cnt_add;
  logic [23:0] sh_new;
  logic [7:0] opc_val;
  logic opc_done;
  logic push;
  logic pop;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] push_byte;
  logic uid_done;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Shift one clock worth of input lanes into the address register
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io,
                                           input logic [2:0] lanes);
    case (lanes)
      LANES_ONE: return {sh[22:0], io[0]};
      LANES_TWO: return {sh[21:0], io[1:0]};
      default: return {sh[19:0], io};
    endcase
  endfunction : shift_in

  // Leading bits of a byte placed on their pins
  function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [2:0] lanes);
    case (lanes)
      LANES_ONE: return {2'b00, b[7], 1'b0};
      LANES_TWO: return {2'b00, b[7:6]};
      default: return b[7:4];
    endcase
  endfunction : top_bits

  // Output enable mask for a lane width
  function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
    case (lanes)
      LANES_ONE: return OE_ONE;
      LANES_TWO: return OE_TWO;
      default: return OE_FOUR;
    endcase
  endfunction : lane_mask

  // Clock groups left in a byte after its first one
  function automatic logic [2:0] groups_left(input logic [2:0] lanes);
    case (lanes)
      LANES_ONE: return 3'h7;
      LANES_TWO: return 3'h3;
      default: return 3'h1;
    endcase
  endfunction : groups_left

  // Dummy clock count for the commands that have one
  function automatic logic [5:0] dummy_len(input logic [7:0] cmd);
    case (cmd)
      OPC_UID: return UID_DUMMY;
      OPC_SFDP: return SFDP_DUMMY;
      default: return QUAD_DUMMY;
    endcase
  endfunction : dummy_len

  // Next byte of the answer for a command
  function automatic logic [7:0] byte_for(input logic [7:0] cmd, input logic [3:0] idx,
                                          input logic a0, input logic [7:0] sfdp);
    logic [63:0] uid;
    uid = UNIQUE_ID << {idx[2:0], 3'b000};
    case (cmd)
      OPC_RD_ID, OPC_RD_DUAL, OPC_RD_QUAD: return (idx[0] ^ a0) ? DEV_ID : MFR_ID;
      OPC_JEDEC: begin
        case (idx)
          4'h0: return MFR_ID;
          4'h1: return MEM_TYPE;
          default: return CAPACITY;
        endcase
      end
      OPC_UID: return idx[3] ? FILL_BYTE : uid[63:56]; // Ones once all eight bytes are out
      OPC_SFDP: return sfdp;
      default: return FILL_BYTE;
    endcase
  endfunction : byte_for

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection and opcode decode helpers

  // Edges of the synchronised serial clock
  assign rise = r.sclk_s2 && !r.sclk_s3;
  assign fall = !r.sclk_s2 && r.sclk_s3;
  assign cnt_add = 6'(r.cnt + {3'b000, r.lanes});
  assign sh_new = shift_in(r.in_sh, r.io_s2, r.lanes);
  assign opc_val = sh_new[7:0];
  assign opc_done = !r.cs_s2 && rise && (r.st == PH_OPC) && (cnt_add == OPC_BITS);

  // Answer generator feeding the buffer
  assign uid_done = (r.cmd == OPC_UID) && (r.gen_idx == UID_BYTES);
  assign push = !r.cs_s2 && (r.st == PH_DATA) && fifo_in_ready;
  assign push_byte = byte_for(r.cmd, r.gen_idx, r.a0, sfdp_data);

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  // Input sampling, instruction phases and output shifting
  always_comb begin
    next_r = r;
    pop = 1'b0;
    next_r.sclk_s1 = sclk;
    next_r.sclk_s2 = r.sclk_s1;
    next_r.sclk_s3 = r.sclk_s2;
    next_r.cs_s1 = cs_n;
    next_r.cs_s2 = r.cs_s1;
    next_r.io_s1 = io_in;
    next_r.io_s2 = r.io_s1;
    if (r.cs_s2) begin
      // Deselected: drop the instruction and float the pins
      next_r.st = PH_OPC;
      next_r.cnt = '0;
      next_r.in_sh = '0;
      next_r.lanes = qpi_mode ? LANES_FOUR : LANES_ONE;
      next_r.io_oe = '0;
      next_r.out_cnt = '0;
      next_r.gen_idx = '0;
    end else begin
      if (rise) begin
        next_r.in_sh = sh_new;
        case (r.st)
          PH_OPC: begin
            next_r.cnt = cnt_add;
            if (cnt_add == OPC_BITS) begin
              next_r.cmd = opc_val;
              next_r.cnt = '0;
              if (power_down) begin
                next_r.st = PH_IGN;
              end else begin
                case (opc_val)
                  OPC_RD_ID: next_r.st = PH_ADDR;
                  OPC_JEDEC: next_r.st = PH_DATA;
                  OPC_RD_DUAL: begin
                    next_r.st = qpi_mode ? PH_IGN : PH_ADDR;
                    next_r.lanes = LANES_TWO;
                  end
                  OPC_RD_QUAD: begin
                    next_r.st = qpi_mode ? PH_IGN : PH_ADDR;
                    next_r.lanes = LANES_FOUR;
                  end
                  OPC_UID: next_r.st = qpi_mode ? PH_IGN : PH_DUM;
                  OPC_SFDP: next_r.st = qpi_mode ? PH_IGN : PH_ADDR;
                  default: next_r.st = PH_IGN;
                endcase
              end
            end
          end
          PH_ADDR: begin
            next_r.cnt = cnt_add;
            if (cnt_add == ADDR_BITS) begin
              next_r.cnt = '0;
              next_r.a0 = sh_new[0];
              next_r.sfdp_ptr = sh_new[7:0];
              if (r.cmd == OPC_RD_ID) begin
                next_r.st = PH_DATA;
              end else if (r.cmd == OPC_SFDP) begin
                next_r.st = PH_DUM;
              end else begin
                next_r.st = PH_MODE;
              end
            end
          end
          PH_MODE: begin
            // Mode byte is taken as not entering continuous mode
            next_r.cnt = cnt_add;
            if (cnt_add == MODE_BITS) begin
              next_r.cnt = '0;
              next_r.st = (r.cmd == OPC_RD_QUAD) ? PH_DUM : PH_DATA;
            end
          end
          PH_DUM: begin
            next_r.cnt = 6'(r.cnt + 6'h01);
            if (6'(r.cnt + 6'h01) == dummy_len(r.cmd)) begin
              next_r.cnt = '0;
              next_r.st = PH_DATA;
            end
          end
          default: begin
            next_r.cnt = r.cnt;
          end
        endcase
      end
      // Output changes on the falling clock edge
      if (fall && (r.st == PH_DATA)) begin
        if (r.out_cnt == '0) begin
          if (fifo_valid) begin
            pop = 1'b1;
            next_r.sh_out = 8'(fifo_data << r.lanes);
            next_r.io_out = top_bits(fifo_data, r.lanes);
            next_r.io_oe = lane_mask(r.lanes);
            next_r.out_cnt = groups_left(r.lanes);
          end
        end else begin
          next_r.io_out = top_bits(r.sh_out, r.lanes);
          next_r.sh_out = 8'(r.sh_out << r.lanes);
          next_r.out_cnt = 3'(r.out_cnt - 3'h1);
        end
      end
      // Advance the answer index and the parameter address
      if (push) begin
        next_r.sfdp_ptr = 8'(r.sfdp_ptr + 8'h01);
        if ((r.cmd == OPC_JEDEC) && (r.gen_idx == JEDEC_LAST)) begin
          next_r.gen_idx = '0;
        end else if (!uid_done) begin
          // Unique number index parks at its end so fill bytes keep flowing
          next_r.gen_idx = 4'(r.gen_idx + 4'h1);
        end
      end
    end
  end

  // State register with clock enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= RESET_STATE;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer and pins

  fir_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .flush(r.cs_s2),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_byte),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // Registered pin drive and lookup address
  assign io_out = r.io_out;
  assign io_oe = r.io_oe;
  assign sfdp_addr = r.sfdp_ptr;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || !clk_en);

  a_deselect_idle: assert property (r.cs_s2 |=> (r.st == PH_OPC) && (r.io_oe == '0))
    else $error("deselect did not return to opcode phase");

  a_drive_data_only: assert property ((r.io_oe != '0) |-> (r.st == PH_DATA))
    else $error("pins driven outside data phase");

  a_power_down_ignore: assert property ((opc_done && power_down) |=> (r.st == PH_IGN))
    else $error("opcode accepted in power-down");

  a_qpi_refuse: assert property ((opc_done && qpi_mode && !power_down &&
    (opc_val == OPC_RD_DUAL || opc_val == OPC_RD_QUAD || opc_val == OPC_UID)) |=> (r.st == PH_IGN))
    else $error("spi only read accepted in qpi mode");

  a_jedec_start: assert property ((opc_done && !power_down && (opc_val == OPC_JEDEC))
    |=> (r.st == PH_DATA))
    else $error("identity read did not start data");

  a_sfdp_forty: assert property ((!r.cs_s2 && rise && (r.st == PH_DUM) && (r.cmd == OPC_SFDP)
    && (r.cnt == 6'h07)) |=> (r.st == PH_DATA))
    else $error("parameter read data not after eight dummies");

  a_quad_dummy: assert property ((!r.cs_s2 && rise && (r.st == PH_MODE) && (r.cmd == OPC_RD_QUAD)
    && (r.cnt == 6'h04)) |=> (r.st == PH_DUM) ##0 (r.cnt == '0))
    else $error("quad read skipped its dummy clocks");

  a_uid_dummy: assert property ((!r.cs_s2 && rise && (r.st == PH_DUM) && (r.cmd == OPC_UID)
    && (r.cnt == 6'h1f)) |=> (r.st == PH_DATA))
    else $error("unique id data not after 32 dummies");

  a_dual_lanes: assert property (((r.st == PH_DATA) && (r.cmd == OPC_RD_DUAL) && (r.io_oe != '0))
    |-> (r.io_oe == OE_TWO))
    else $error("dual read drives wrong pins");

  a_id_first: assert property ((push && (r.cmd == OPC_RD_ID) && (r.gen_idx == 4'h0))
    |-> (push_byte == (r.a0 ? DEV_ID : MFR_ID)))
    else $error("wrong first id byte");

  a_sfdp_step: assert property ((push && (r.cmd == OPC_SFDP))
    |=> (r.sfdp_ptr == 8'($past(r.sfdp_ptr) + 8'h01)))
    else $error("parameter address did not advance");

  c_jedec_out: cover property ((r.cmd == OPC_JEDEC) && (r.io_oe == OE_ONE));
  c_sfdp_out: cover property ((r.cmd == OPC_SFDP) && (r.io_oe == OE_ONE));
  c_quad_out: cover property ((r.cmd == OPC_RD_QUAD) && (r.io_oe == OE_FOUR));
  c_uid_out: cover property ((r.cmd == OPC_UID) && uid_done);
endmodule : fir_id_readout
`default_nettype wire

// >>> src/fir_pkg.sv
// Package of constants and state types for the flash identification readout
// Function
// - Opcode 90h, zero address, then manufacturer then device ID, MSB first
// - Start address 000001h in 90h/92h/94h returns device ID first
// - ID bytes keep alternating while chip select stays low
// - Opcode 92h: address and mode bits two per clock, IDs two per clock
// - Opcode 94h: address and mode four per clock, four dummies, quad output
// - Dual, quad and unique ID reads accepted only in standard SPI mode
// - Opcode 4Bh, four dummy bytes, then 64-bit unique number shifted out
// - Unique number is fixed at build time and read only
// - Opcode 9Fh returns manufacturer, memory type, capacity, MSB first
// - 90h and 9Fh reads accepted in both SPI and quad peripheral mode
// - Opcode 5Ah, 24-bit address, eight dummies, data from 40th falling edge
// - Parameter address bits 23..8 zero, bits 7..0 pick starting byte
// - Parameter area holds exactly one parameter identification table
// - In power-down every identification opcode here is ignored
package fir_pkg;
  // Opcodes
  localparam logic [7:0] OPC_RD_ID = 8'h90;
  localparam logic [7:0] OPC_RD_DUAL = 8'h92;
  localparam logic [7:0] OPC_RD_QUAD = 8'h94;
  localparam logic [7:0] OPC_UID = 8'h4b;
  localparam logic [7:0] OPC_JEDEC = 8'h9f;
  localparam logic [7:0] OPC_SFDP = 8'h5a;
  // Lane widths and output enable masks
  localparam logic [2:0] LANES_ONE = 3'h1;
  localparam logic [2:0] LANES_TWO = 3'h2;
  localparam logic [2:0] LANES_FOUR = 3'h4;
  localparam logic [3:0] OE_ONE = 4'h2;
  localparam logic [3:0] OE_TWO = 4'h3;
  localparam logic [3:0] OE_FOUR = 4'hf;
  // Phase lengths in bits or clocks, answer limits and fill byte
  localparam logic [5:0] OPC_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] QUAD_DUMMY = 6'h04;
  localparam logic [5:0] SFDP_DUMMY = 6'h08;
  localparam logic [5:0] UID_DUMMY = 6'h20;
  localparam logic [3:0] UID_BYTES = 4'h8;
  localparam logic [3:0] JEDEC_LAST = 4'h2;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  // Link timing
  localparam int SYS_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_SYS_CYCLES = SCLK_PERIOD_NS / SYS_PERIOD_NS;
  // Output buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    PH_OPC = 3'b000,
    PH_ADDR = 3'b001,
    PH_MODE = 3'b010,
    PH_DUM = 3'b011,
    PH_DATA = 3'b100,
    PH_IGN = 3'b101
  } fir_phase_type;

  typedef struct packed {
    fir_phase_type st;
    logic [7:0] cmd;
    logic [23:0] in_sh;
    logic [2:0] lanes;
    logic [5:0] cnt;
    logic a0;
    logic [3:0] gen_idx;
    logic [7:0] sfdp_ptr;
    logic [7:0] sh_out;
    logic [2:0] out_cnt;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
  } fir_state_type;

  localparam fir_state_type RESET_STATE = '{st: PH_OPC, lanes: LANES_ONE,
    cs_s1: 1'b1, cs_s2: 1'b1, default: '0};
endpackage : fir_pkg

// >>> src/fir_fifo.sv
// Output byte buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module fir_fifo
  import fir_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fir_fifo_state_type;

  fir_fifo_state_type r;
  fir_fifo_state_type next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Handshakes from the occupancy count
  assign in_ready = r.cnt != (AW + 1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_r = r;
    if (flush) begin
      next_r = '0;
    end else begin
      if (push) begin
        next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : AW'(r.wp + 1'b1);
      end
      if (pop) begin
        next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : AW'(r.rp + 1'b1);
      end
      next_r.cnt = (AW + 1)'(r.cnt + {AW'(0), push} - {AW'(0), pop});
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // Storage
  always_ff @(posedge clk_sys) begin
    if (clk_en && push && !flush) begin
      mem[r.wp] <= in_data;
    end
  end
endmodule : fir_fifo
`default_nettype wire

// >>> tb/fir_host_model.sv
// Host model that drives chip select, serial clock and data lanes
`timescale 1ns/100ps
`default_nettype none
module fir_host_model
  import fir_pkg::*;
(
  // System clock that times the link
  input wire logic clk_sys,
  // Lines toward the device
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_in,
  // Lines from the device
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  int half_cycles;
  logic [3:0] oe_seen;

  // Idle: deselected, clock parked low
  initial begin
    half_cycles = SCLK_SYS_CYCLES / 2;
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'h5;
    oe_seen = 4'h0;
  end

  // Wait whole system cycles, then step just past the edge
  task automatic wait_sys(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_sys

  // One serial clock: lanes change in the low phase, device lines sampled on the rise
  task automatic one_clk(input logic [3:0] val, input logic [3:0] drv, output logic [3:0] smp);
    io_in = (val & drv) | (~io_in & ~drv); // Released lines toggle, never keep a stale value
    wait_sys(half_cycles);
    sclk = 1'b1;
    smp = io_out;
    oe_seen = io_oe;
    wait_sys(half_cycles);
    sclk = 1'b0;
  endtask : one_clk

  // Shift n bits out of the top of v, l lanes per clock, MSB first
  task automatic send(input logic [31:0] v, input int n, input int l);
    logic [3:0] smp;
    for (int i = 0; i < n; i += l) begin
      one_clk(v[31:28] >> (4 - l), 4'hf >> (4 - l), smp);
      v = v << l;
    end
  endtask : send

  // Whole instruction frame: opcode, address and mode, dummies, then receive
  task automatic op(input logic [7:0] opc, input logic qpi, input logic [31:0] adm, input int an, input int al,
                    input int dum, input int rl, input int rn, output logic [127:0] rx);
    logic [3:0] smp;
    logic [3:0] v;
    rx = '0;
    cs_n = 1'b0;
    wait_sys(half_cycles);
    send({opc, 24'h0}, 8, qpi ? 4 : 1);
    send(adm, an, al);
    for (int i = 0; i < dum; i++) begin
      one_clk(4'h0, 4'h0, smp);
    end
    for (int i = 0; i < rn; i += rl) begin
      one_clk(4'h0, 4'h0, smp);
      v = (rl == 1) ? {3'h0, smp[1]} : (smp & (4'hf >> (4 - rl)));
      rx = (rx << rl) | {124'h0, v};
    end
    cs_n = 1'b1;
    wait_sys(2 * half_cycles);
  endtask : op
endmodule : fir_host_model
`default_nettype wire

// >>> tb/test_flash_identification_readout.sv
// Self-checking bench for the identification readout
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_flash_identification_readout
  import fir_pkg::*;
;
  localparam logic [7:0] P_MFR = 8'h3c; // Arbitrary value
  localparam logic [7:0] P_DEV = 8'h7b; // Arbitrary value
  localparam logic [7:0] P_MEM = 8'h26; // Arbitrary value
  localparam logic [7:0] P_CAP = 8'h91; // Arbitrary value
  localparam logic [63:0] P_UID = 64'hfedc_ba98_7654_3210; // Arbitrary value
  logic clk_sys;
  logic rst;
  logic clk_en;
  logic qpi_mode;
  logic power_down;
  wire logic cs_n;
  wire logic sclk;
  wire logic [3:0] io_in;
  wire logic [3:0] io_out;
  wire logic [3:0] io_oe;
  wire logic [7:0] sfdp_addr;
  wire logic [7:0] sfdp_data;
  int num_errors = 0;
  int comparisons = 0;

  // Parameter area contents, a fixed function of the address
  function automatic logic [7:0] sfdp_rom(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'ha5;
  endfunction : sfdp_rom
  assign sfdp_data = sfdp_rom(sfdp_addr);

  fir_id_readout #(.MFR_ID(P_MFR), .DEV_ID(P_DEV), .MEM_TYPE(P_MEM), .CAPACITY(P_CAP), .UNIQUE_ID(P_UID)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .qpi_mode(qpi_mode), .power_down(power_down), .sfdp_addr(sfdp_addr), .sfdp_data(sfdp_data));
  fir_host_model host_u (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Mode levels change just after a clock edge, while deselected
  task automatic set_mode(input logic q, input logic p);
    @(posedge clk_sys);
    #1;
    qpi_mode = q;
    power_down = p;
  endtask : set_mode

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_jedec;
    logic [127:0] rx;
    host_u.op(OPC_JEDEC, 1'b0, 32'h0, 0, 1, 0, 1, 48, rx);
    `CHK(rx[47:0], {P_MFR, P_MEM, P_CAP, P_MFR, P_MEM, P_CAP})
    `CHK(host_u.oe_seen, OE_ONE)
    $display("test jedec done");
  endtask : t_jedec

  task automatic t_ids;
    logic [127:0] rx;
    logic [31:0] exp;
    for (int k = 0; k < 6; k++) begin
      exp = k[0] ? {P_DEV, P_MFR, P_DEV, P_MFR} : {P_MFR, P_DEV, P_MFR, P_DEV};
      case (k / 2)
        0: host_u.op(OPC_RD_ID, 1'b0, {23'h0, k[0], 8'h0}, 24, 1, 0, 1, 32, rx);
        1: host_u.op(OPC_RD_DUAL, 1'b0, {23'h0, k[0], 8'hf0}, 32, 2, 0, 2, 32, rx);
        default: host_u.op(OPC_RD_QUAD, 1'b0, {23'h0, k[0], 8'hf5}, 32, 4, 4, 4, 32, rx);
      endcase
      `CHK(rx[31:0], exp)
      `CHK(host_u.oe_seen, (k < 2) ? OE_ONE : (k < 4) ? OE_TWO : OE_FOUR)
    end
    $display("test id reads done");
  endtask : t_ids

  // Slow host clock lets the output buffer fill and stall
  task automatic t_uid;
    logic [127:0] rx;
    host_u.half_cycles = 12;
    host_u.op(OPC_UID, 1'b0, 32'h0, 0, 1, 32, 1, 72, rx);
    host_u.half_cycles = 4;
    `CHK(rx[71:0], {P_UID, FILL_BYTE})
    host_u.op(OPC_UID, 1'b0, 32'h0, 0, 1, 32, 1, 64, rx);
    `CHK(rx[63:0], P_UID)
    $display("test unique id done");
  endtask : t_uid

  task automatic t_sfdp;
    logic [127:0] rx;
    host_u.op(OPC_SFDP, 1'b0, {24'h0000fe, 8'h0}, 24, 1, 8, 1, 24, rx);
    `CHK(rx[23:0], {sfdp_rom(8'hfe), sfdp_rom(8'hff), sfdp_rom(8'h00)})
    $display("test parameter area done");
  endtask : t_sfdp

  task automatic t_qpi;
    logic [127:0] rx;
    logic [7:0] refused [4] = '{OPC_RD_DUAL, OPC_RD_QUAD, OPC_UID, OPC_SFDP};
    set_mode(1'b1, 1'b0);
    host_u.op(OPC_RD_ID, 1'b1, 32'h0, 24, 4, 0, 4, 32, rx);
    `CHK(rx[31:0], {P_MFR, P_DEV, P_MFR, P_DEV})
    host_u.op(OPC_JEDEC, 1'b1, 32'h0, 0, 4, 0, 4, 24, rx);
    `CHK(rx[23:0], {P_MFR, P_MEM, P_CAP})
    `CHK(host_u.oe_seen, OE_FOUR)
    foreach (refused[i]) begin
      host_u.op(refused[i], 1'b1, 32'h0, 24, 4, 0, 4, 16, rx);
      `CHK(host_u.oe_seen, 4'h0)
    end
    set_mode(1'b0, 1'b0);
    $display("test quad peripheral mode done");
  endtask : t_qpi

  task automatic t_pdown;
    logic [127:0] rx;
    logic [7:0] all_ops [6] = '{OPC_RD_ID, OPC_RD_DUAL, OPC_RD_QUAD, OPC_UID, OPC_JEDEC, OPC_SFDP};
    set_mode(1'b0, 1'b1);
    foreach (all_ops[i]) begin
      host_u.op(all_ops[i], 1'b0, 32'h0, 24, 1, 0, 1, 16, rx);
      `CHK(host_u.oe_seen, 4'h0)
    end
    set_mode(1'b0, 1'b0);
    $display("test power down done");
  endtask : t_pdown

  task automatic t_abort;
    logic [127:0] rx;
    host_u.op(OPC_JEDEC, 1'b0, 32'h0, 0, 1, 0, 1, 5, rx);
    `CHK(rx[4:0], P_MFR[7:3])
    `CHK(io_oe, 4'h0)
    host_u.op(OPC_JEDEC, 1'b0, 32'h0, 0, 1, 0, 1, 24, rx);
    `CHK(rx[23:0], {P_MFR, P_MEM, P_CAP})
    $display("test abort done");
  endtask : t_abort

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    qpi_mode = 1'b0;
    power_down = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    t_jedec();
    t_ids();
    t_uid();
    t_sfdp();
    t_qpi();
    t_pdown();
    t_abort();
    close_out();
  end

  // Watchdog, well beyond the expected run
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end
endmodule : test_flash_identification_readout
`default_nettype wire
